/* core/rdb_lut.sv */
// registered decode of a 4-bit acceleration code into a rate
// assumes the code comes from a register in the same clock domain
`timescale 1ns/100ps
module rdb_lut #(
  parameter bit ZERO_AT_CODE0 = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // code in, rate out
  input wire logic [3:0] i_code,
  output logic [rdb_pkg::RDB_RATE_W-1:0] o_rate
);
  import rdb_pkg::*;

  // table lookup, with optional zero for the lowest code
  wire logic [RDB_RATE_W-1:0] next_rate;
  assign next_rate = (ZERO_AT_CODE0 && i_code == 4'h0) ? '0 : RDB_ACCEL_TBL[i_code];

  // rate register, read data leave from a flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rate <= '0;
    end else begin
      o_rate <= next_rate;
    end
  end
endmodule

/* core/rdb_top.sv */
// reverse drive and active braking configuration bank with decoders
// assumes a register master on the plain strobe port and synchronous inputs
// What this block does
// - one read/write config word, resets zero, top bit parity
// - linear accel code decodes to sixteen rising rates
// - quadratic accel code decodes, code zero gives zero
// - braking bus current limit, 0.5 A then 1-7 A
// - braking proportional gain, field over two to seven
// - braking integral gain, field over two to nine
// - reverse decel goes open loop below speed fraction
// - reversal phase current flagged above selected limit
`timescale 1ns/100ps
module rdb_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [rdb_pkg::RDB_ADDR_W-1:0] i_addr,
  input wire logic [rdb_pkg::RDB_DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [rdb_pkg::RDB_DATA_W-1:0] o_rd_data,
  // motor state from the control core
  input wire logic i_reverse_decel,
  input wire logic [rdb_pkg::RDB_SPEED_W-1:0] i_motor_speed,
  input wire logic [rdb_pkg::RDB_SPEED_W-1:0] i_max_speed,
  input wire logic i_reversing,
  input wire logic [rdb_pkg::RDB_MA_W-1:0] i_phase_current_ma,
  // decoded settings
  output logic [rdb_pkg::RDB_RATE_W-1:0] o_linear_accel_rate,
  output logic [rdb_pkg::RDB_RATE_W-1:0] o_quadratic_accel_rate,
  output logic [rdb_pkg::RDB_MA_W-1:0] o_brake_current_limit_ma,
  output logic [rdb_pkg::RDB_GAIN_W-1:0] o_brake_prop_gain,
  output logic [rdb_pkg::RDB_GAIN_W-1:0] o_brake_integral_gain,
  output logic [rdb_pkg::RDB_MA_W-1:0] o_reverse_current_limit_ma,
  // status and control decisions
  output logic o_parity_error,
  output logic o_reverse_openloop,
  output logic o_current_over_limit
);
  import rdb_pkg::*;

  // stored configuration
  logic [RDB_DATA_W-1:0] reverse_drive_config; // main config word
  logic [5:0] handoff_config; // switch speed and reversal current codes

  // address decode
  wire logic hit_cfg; // config word selected
  wire logic hit_handoff; // handoff word selected
  wire logic hit_status; // status word selected
  assign hit_cfg = (i_addr == RDB_OFS_CFG);
  assign hit_handoff = (i_addr == RDB_OFS_HANDOFF);
  assign hit_status = (i_addr == RDB_OFS_STATUS);

  // write enables
  wire logic wr_cfg;
  wire logic wr_handoff;
  assign wr_cfg = i_wr_en && hit_cfg;
  assign wr_handoff = i_wr_en && hit_handoff;

  // field views of the config word
  wire logic [3:0] reverse_linear_accel_coef;
  wire logic [3:0] reverse_quadratic_accel_coef;
  wire logic [2:0] brake_current_code;
  wire logic [9:0] brake_loop_prop_gain;
  wire logic [9:0] brake_loop_integral_gain;
  assign reverse_linear_accel_coef = reverse_drive_config[RDB_LIN_HI:RDB_LIN_LO];
  assign reverse_quadratic_accel_coef = reverse_drive_config[RDB_QUAD_HI:RDB_QUAD_LO];
  assign brake_current_code = reverse_drive_config[RDB_BCUR_HI:RDB_BCUR_LO];
  assign brake_loop_prop_gain = reverse_drive_config[RDB_PGAIN_HI:RDB_PGAIN_LO];
  assign brake_loop_integral_gain = reverse_drive_config[RDB_IGAIN_HI:RDB_IGAIN_LO];

  // field views of the handoff word
  wire logic [3:0] reverse_openloop_switch_speed;
  wire logic [1:0] reverse_openloop_current_limit;
  assign reverse_openloop_switch_speed = handoff_config[RDB_SWSPD_HI:RDB_SWSPD_LO];
  assign reverse_openloop_current_limit = handoff_config[RDB_RCUR_HI:RDB_RCUR_LO];

  // even parity over the whole word, bit 31 included
  wire logic parity_bad;
  assign parity_bad = ^reverse_drive_config;

  // switch-over compare: speed*1000 < max*permille
  wire logic [RDB_PROD_W-1:0] speed_scaled;
  wire logic [RDB_PROD_W-1:0] limit_scaled;
  wire logic below_switch;
  assign speed_scaled = RDB_PROD_W'(i_motor_speed) * RDB_PERMILLE_FULL;
  assign limit_scaled = RDB_PROD_W'(i_max_speed)
                      * RDB_PROD_W'(RDB_SWSPD_TBL[reverse_openloop_switch_speed]);
  assign below_switch = speed_scaled < limit_scaled;

  // reversal current check against the selected limit
  wire logic [RDB_MA_W-1:0] rev_limit;
  wire logic over_limit;
  assign rev_limit = RDB_RCUR_TBL[reverse_openloop_current_limit];
  assign over_limit = i_reversing && (i_phase_current_ma > rev_limit);

  // read mux, unmapped addresses read zero
  wire logic [RDB_DATA_W-1:0] status_word;
  wire logic [RDB_DATA_W-1:0] rd_mux;
  assign status_word = RDB_DATA_W'({o_current_over_limit, o_reverse_openloop, o_parity_error});
  assign rd_mux = hit_cfg ? reverse_drive_config :
                  hit_handoff ? RDB_DATA_W'(handoff_config) :
                  hit_status ? status_word : '0;

  // config word storage, every bit read/write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reverse_drive_config <= RDB_CFG_RST;
    end else if (wr_cfg) begin
      reverse_drive_config <= i_wr_data;
    end
  end

  // handoff word storage, low six bits only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      handoff_config <= RDB_HANDOFF_RST;
    end else if (wr_handoff) begin
      handoff_config <= i_wr_data[5:0];
    end
  end

  // read data stand for one cycle after the strobe only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= i_rd_en ? rd_mux : '0;
    end
  end

  // two acceleration decoders, the quadratic one zero at code 0
  generate
    for (genvar g = 0; g < 2; g++) begin : g_accel
      wire logic [RDB_RATE_W-1:0] rate;
      rdb_lut #(
        .ZERO_AT_CODE0(g == 1)
      ) u_lut (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_code(g == 0 ? reverse_linear_accel_coef : reverse_quadratic_accel_coef),
        .o_rate(rate)
      );
    end
  endgenerate
  assign o_linear_accel_rate = g_accel[0].rate;
  assign o_quadratic_accel_rate = g_accel[1].rate;

  // braking settings, gains passed as raw fixed point
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_brake_current_limit_ma <= '0;
      o_brake_prop_gain <= '0;
      o_brake_integral_gain <= '0;
    end else begin
      o_brake_current_limit_ma <= RDB_BCUR_TBL[brake_current_code];
      o_brake_prop_gain <= brake_loop_prop_gain;
      o_brake_integral_gain <= brake_loop_integral_gain;
    end
  end

  // reversal decisions and parity flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_parity_error <= 1'b0;
      o_reverse_openloop <= 1'b0;
      o_current_over_limit <= 1'b0;
      o_reverse_current_limit_ma <= '0;
    end else begin
      o_parity_error <= parity_bad;
      o_reverse_openloop <= i_reverse_decel && below_switch;
      o_current_over_limit <= over_limit;
      o_reverse_current_limit_ma <= rev_limit;
    end
  end

  // checks on the bank and its decoders
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // write lands, then reads back the same word
  property p_cfg_roundtrip;
    logic [31:0] d;
    (wr_cfg, d = i_wr_data) ##1 (i_rd_en && hit_cfg && !i_wr_en) |=> (o_rd_data == d);
  endproperty
  a_cfg_roundtrip: assert property (p_cfg_roundtrip)
    else $error("config word did not read back");

  // parity flag follows the stored word two cycles after a write
  property p_parity;
    wr_cfg ##1 !wr_cfg |=> (o_parity_error == ^$past(i_wr_data, 2));
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag wrong");

  // linear rate from code after two cycles
  property p_linear;
    wr_cfg ##1 !wr_cfg |=> o_linear_accel_rate == RDB_ACCEL_TBL[$past(i_wr_data[30:27], 2)];
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear rate decode wrong");

  // quadratic rate is zero for code zero
  property p_quad_zero;
    (reverse_quadratic_accel_coef == 4'h0) ##1 (reverse_quadratic_accel_coef == 4'h0)
      |-> o_quadratic_accel_rate == '0;
  endproperty
  a_quad_zero: assert property (p_quad_zero)
    else $error("quadratic rate not zero at code zero");

  // quadratic rate equals table above code zero
  property p_quad_tbl;
    (reverse_quadratic_accel_coef != 4'h0) && $stable(reverse_drive_config)
      |=> o_quadratic_accel_rate == RDB_ACCEL_TBL[$past(reverse_quadratic_accel_coef)];
  endproperty
  a_quad_tbl: assert property (p_quad_tbl)
    else $error("quadratic rate decode wrong");

  // braking current in mA, 500 at code 0 else code times 1000
  property p_brake_cur;
    wr_cfg |=> ##1 o_brake_current_limit_ma == (($past(i_wr_data[22:20], 2) == 3'h0) ?
      13'h01F4 : 13'($past(i_wr_data[22:20], 2)) * 13'h03E8);
  endproperty
  a_brake_cur: assert property (p_brake_cur)
    else $error("braking current limit wrong");

  // proportional gain field passes through
  property p_prop;
    wr_cfg |=> ##1 o_brake_prop_gain == $past(i_wr_data[19:10], 2);
  endproperty
  a_prop: assert property (p_prop)
    else $error("proportional gain wrong");

  // integral gain field passes through
  property p_integ;
    wr_cfg |=> ##1 o_brake_integral_gain == $past(i_wr_data[9:0], 2);
  endproperty
  a_integ: assert property (p_integ)
    else $error("integral gain wrong");

  // open loop only while decelerating in reverse
  property p_openloop;
    !i_reverse_decel |=> !o_reverse_openloop;
  endproperty
  a_openloop: assert property (p_openloop)
    else $error("open loop outside reverse deceleration");

  // zero speed always below a nonzero maximum
  property p_openloop_zero;
    i_reverse_decel && i_motor_speed == '0 && i_max_speed != '0 |=> o_reverse_openloop;
  endproperty
  a_openloop_zero: assert property (p_openloop_zero)
    else $error("open loop missed at standstill");

  // over-limit only while reversing above the selected limit
  property p_overlimit;
    o_current_over_limit |-> $past(i_reversing)
      && $past(i_phase_current_ma) > o_reverse_current_limit_ma;
  endproperty
  a_overlimit: assert property (p_overlimit)
    else $error("over-limit flag without cause");

  // main scenarios
  c_write_cfg: cover property (wr_cfg ##1 i_rd_en && hit_cfg);
  c_parity: cover property (o_parity_error);
  c_openloop: cover property (o_reverse_openloop);
  c_overlimit: cover property (o_current_over_limit);
endmodule

/* inc/rdb_pkg.sv */
// constants for the reverse drive and braking configuration bank
// assumes a plain strobe register port with word-wide data
package rdb_pkg;
  // widths
  localparam int RDB_ADDR_W = 8;
  localparam int RDB_DATA_W = 32;
  localparam int RDB_RATE_W = 20;
  localparam int RDB_MA_W = 13;
  localparam int RDB_GAIN_W = 10;
  localparam int RDB_SPEED_W = 16;
  localparam int RDB_PROD_W = 26;
  // register offsets (word index on the port)
  localparam logic [7:0] RDB_OFS_CFG = 8'h82;
  localparam logic [7:0] RDB_OFS_HANDOFF = 8'hA0;
  localparam logic [7:0] RDB_OFS_STATUS = 8'hA1;
  // reset values
  localparam logic [31:0] RDB_CFG_RST = 32'h00000000;
  localparam logic [5:0] RDB_HANDOFF_RST = 6'h00;
  // config field positions
  localparam int RDB_PAR_BIT = 31;
  localparam int RDB_LIN_HI = 30;
  localparam int RDB_LIN_LO = 27;
  localparam int RDB_QUAD_HI = 26;
  localparam int RDB_QUAD_LO = 23;
  localparam int RDB_BCUR_HI = 22;
  localparam int RDB_BCUR_LO = 20;
  localparam int RDB_PGAIN_HI = 19;
  localparam int RDB_PGAIN_LO = 10;
  localparam int RDB_IGAIN_HI = 9;
  localparam int RDB_IGAIN_LO = 0;
  // handoff register field positions
  localparam int RDB_SWSPD_HI = 5;
  localparam int RDB_SWSPD_LO = 2;
  localparam int RDB_RCUR_HI = 1;
  localparam int RDB_RCUR_LO = 0;
  // status register bit positions
  localparam int RDB_ST_PAR = 0;
  localparam int RDB_ST_OPENLOOP = 1;
  localparam int RDB_ST_OVER = 2;
  // gain scaling: fraction bits of the two braking gains
  localparam int RDB_PGAIN_FRAC = 7;
  localparam int RDB_IGAIN_FRAC = 9;
  // acceleration rates in units of 0.01 Hz/s (or Hz/s2)
  localparam logic [19:0] RDB_ACCEL_TBL [16] = '{
    20'h00001, 20'h00005, 20'h00064, 20'h000FA, 20'h001F4, 20'h003E8,
    20'h009C4, 20'h01388, 20'h01D4C, 20'h02710, 20'h061A8, 20'h0C350,
    20'h124F8, 20'h186A0, 20'h7A120, 20'hF4240};
  // braking bus current limit in mA
  localparam logic [12:0] RDB_BCUR_TBL [8] = '{
    13'h01F4, 13'h03E8, 13'h07D0, 13'h0BB8, 13'h0FA0, 13'h1388, 13'h1770, 13'h1B58};
  // reversal open-loop phase current limit in mA
  localparam logic [12:0] RDB_RCUR_TBL [4] = '{13'h05DC, 13'h09C4, 13'h0DAC, 13'h1388};
  // switch-over speed in per mille of maximum speed
  localparam logic [9:0] RDB_SWSPD_TBL [16] = '{
    10'h019, 10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h0FA,
    10'h12C, 10'h190, 10'h1F4, 10'h258, 10'h2BC, 10'h320, 10'h384, 10'h3E8};
  localparam logic [25:0] RDB_PERMILLE_FULL = 26'h00003E8;
endpackage

/* sim/reverse_drive_brake_config_tb.sv */
// self-checking bench for the reverse drive and braking config bank
// assumes rdb_top with a plain strobe register port and a 125 MHz clock
`timescale 1ns/100ps
module reverse_drive_brake_config_tb;
  import rdb_pkg::*;
  // design ports
  logic i_clk, i_rst_n, i_wr_en, i_rd_en, i_reverse_decel, i_reversing;
  logic [RDB_ADDR_W-1:0] i_addr;
  logic [RDB_DATA_W-1:0] i_wr_data, o_rd_data;
  logic [RDB_SPEED_W-1:0] i_motor_speed, i_max_speed;
  logic [RDB_MA_W-1:0] i_phase_current_ma, o_brake_current_limit_ma, o_reverse_current_limit_ma;
  logic [RDB_RATE_W-1:0] o_linear_accel_rate, o_quadratic_accel_rate;
  logic [RDB_GAIN_W-1:0] o_brake_prop_gain, o_brake_integral_gain;
  logic o_parity_error, o_reverse_openloop, o_current_over_limit;
  // bench state
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h4e6e3ce1;
  logic [31:0] rd, d;
  logic [3:0] sc;
  logic [1:0] rc;
  logic [31:0] cw; // config word standing during the motor side tests
  logic ol, ov; // expected open loop and over-limit decisions

  rdb_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_reverse_decel(i_reverse_decel), .i_motor_speed(i_motor_speed),
    .i_max_speed(i_max_speed), .i_reversing(i_reversing),
    .i_phase_current_ma(i_phase_current_ma), .o_linear_accel_rate(o_linear_accel_rate),
    .o_quadratic_accel_rate(o_quadratic_accel_rate),
    .o_brake_current_limit_ma(o_brake_current_limit_ma),
    .o_brake_prop_gain(o_brake_prop_gain), .o_brake_integral_gain(o_brake_integral_gain),
    .o_reverse_current_limit_ma(o_reverse_current_limit_ma),
    .o_parity_error(o_parity_error), .o_reverse_openloop(o_reverse_openloop),
    .o_current_over_limit(o_current_over_limit));

  // free-running clock, 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rdw(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1 v = o_rd_data;
  endtask

  // write strobe, then a read strobe of the same place right behind it
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1 r = o_rd_data;
  endtask

  // quadratic code zero means no quadratic term
  function automatic logic [31:0] quad_exp(input logic [3:0] c);
    return (c == 4'h0) ? 32'h0 : 32'(RDB_ACCEL_TBL[c]);
  endfunction

  // write a config word, read it back, then check every decoded field
  task automatic cfg(input logic [31:0] v);
    wr_rd(RDB_OFS_CFG, v, rd);
    chk("config readback", v, rd);
    chk("linear rate", 32'(RDB_ACCEL_TBL[v[30:27]]), 32'(o_linear_accel_rate));
    chk("quadratic rate", quad_exp(v[26:23]), 32'(o_quadratic_accel_rate));
    chk("brake current", 32'(RDB_BCUR_TBL[v[22:20]]), 32'(o_brake_current_limit_ma));
    chk("prop gain", 32'(v[19:10]), 32'(o_brake_prop_gain));
    chk("integral gain", 32'(v[9:0]), 32'(o_brake_integral_gain));
    chk("parity flag", 32'(^v), 32'(o_parity_error));
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  // main sequence
  initial begin
    i_rst_n = 1'b0;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_addr = 8'h00;
    i_wr_data = 32'h0;
    i_reverse_decel = 1'b0;
    i_reversing = 1'b0;
    i_motor_speed = 16'h0;
    i_max_speed = 16'h0;
    i_phase_current_ma = 13'h0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // reset values and code-zero decodes
    rdw(RDB_OFS_CFG, rd);
    chk("config reset", RDB_CFG_RST, rd);
    rdw(RDB_OFS_HANDOFF, rd);
    chk("handoff reset", 32'h0, rd);
    chk("linear code0", 32'(RDB_ACCEL_TBL[0]), 32'(o_linear_accel_rate));
    chk("quad code0", 32'h0, 32'(o_quadratic_accel_rate));
    chk("brake code0", 32'h1F4, 32'(o_brake_current_limit_ma));
    chk("reverse code0", 32'h5DC, 32'(o_reverse_current_limit_ma));
    // every code of the accel and braking current tables, gains random
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      cfg({d[31], i[3:0], i[3:0], i[2:0], d[19:0]});
    end
    // boundary words and random words
    cfg(32'hFFFFFFFF);
    cfg(32'h80000000);
    cfg(32'h000FFC00);
    for (int i = 0; i < 20; i++) begin
      cfg($random(seed));
    end
    // unmapped place: write ignored, read zero
    d = $random(seed);
    cfg(d);
    wr(8'h55, ~d);
    rdw(8'h55, rd);
    chk("unmapped read", 32'h0, rd);
    rdw(RDB_OFS_CFG, rd);
    chk("config after stray write", d, rd);
    cw = d;
    // handoff word keeps only its low six bits
    d = $random(seed);
    wr(RDB_OFS_HANDOFF, d);
    rdw(RDB_OFS_HANDOFF, rd);
    chk("handoff readback", {26'h0, d[5:0]}, rd);
    // motor side decisions, boundary cases first
    for (int k = 0; k < 40; k++) begin
      d = $random(seed);
      sc = d[5:2];
      rc = d[1:0];
      wr(RDB_OFS_HANDOFF, {26'h0, sc, rc});
      d = $random(seed);
      i_reverse_decel <= (k < 5) ? 1'b1 : d[0];
      i_reversing <= (k < 4) ? 1'b1 : d[1];
      i_max_speed <= (k < 4) ? 16'd1000 : (k == 4) ? 16'hFFFF : d[31:16];
      i_motor_speed <= (k < 4) ? 16'(RDB_SWSPD_TBL[sc] - 10'(k % 2)) :
        (k == 4) ? 16'h0000 : 16'(d[31:16] >> d[3:2]);
      i_phase_current_ma <= (k < 4) ? RDB_RCUR_TBL[rc] + 13'(k % 2) : d[14:2];
      @(posedge i_clk);
      @(posedge i_clk);
      #1;
      chk("reverse limit", 32'(RDB_RCUR_TBL[rc]), 32'(o_reverse_current_limit_ma));
      ol = i_reverse_decel && (32'(i_motor_speed) * 32'd1000 <
        32'(i_max_speed) * 32'(RDB_SWSPD_TBL[sc]));
      ov = i_reversing && (i_phase_current_ma > RDB_RCUR_TBL[rc]);
      chk("open loop", 32'(ol), 32'(o_reverse_openloop));
      chk("over limit", 32'(ov), 32'(o_current_over_limit));
      rdw(RDB_OFS_STATUS, rd);
      chk("status word", {29'h0, ov, ol, ^cw}, rd);
    end
    // reset in mid-run clears the config word
    cfg(32'h7FFFFFFF);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdw(RDB_OFS_CFG, rd);
    chk("config after reset", RDB_CFG_RST, rd);
    chk("parity after reset", 32'h0, 32'(o_parity_error));
    chk("linear after reset", 32'(RDB_ACCEL_TBL[0]), 32'(o_linear_accel_rate));
    stop_test();
  end
endmodule
